// *** sapc_core.sv ***
module sapc_core #(
    parameter int unsigned RES_BITS = sapc_pkg::WIDE_BITS,
    parameter int unsigned SETTLE_CYC = sapc_pkg::REF_SETTLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Serial link pins
    input wire logic shift_clk_i,
    input wire logic conversion_trigger_i,
    output logic serial_result_out_o,
    output logic serial_result_oe_o,
    // Analog front-end result
    input wire logic [RES_BITS-1:0] sample_code_i,
    input wire logic over_range_i,
    input wire logic under_range_i,
    // Power status
    output logic nap_o,
    output logic sleep_o,
    output logic ref_powered_o,
    output logic ref_settled_o
);
    localparam int unsigned SW = $clog2(SETTLE_CYC + 1);
    localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYC);
    localparam logic [4:0] LAST_EDGE = 5'(sapc_pkg::FRAME_EDGES);
    localparam logic [4:0] FIRST_EDGE = 5'(sapc_pkg::FIRST_BIT_EDGE);
    localparam logic [4:0] END_EDGE = 5'(sapc_pkg::FIRST_BIT_EDGE + RES_BITS);
    localparam logic [2:0] NAP_N = 3'(sapc_pkg::NAP_TRIGGERS);
    localparam logic [2:0] SLEEP_N = 3'(sapc_pkg::SLEEP_TRIGGERS);

    logic [2:0] sck_sync;
    logic [2:0] cnv_sync;
    logic sck_rise;
    logic cnv_rise;
    logic busy;
    logic [4:0] edge_cnt;
    logic [2:0] trig_cnt;
    logic [RES_BITS-1:0] shreg;
    logic [RES_BITS-1:0] held_code;
    logic [SW-1:0] settle_cnt;
    sapc_pkg::sapc_power_e power;

    // Pins are asynchronous to sys_clk; bit 0 feeds only bit 1
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sck_sync <= 3'h0;
            cnv_sync <= 3'h0;
        end else begin
            sck_sync <= {sck_sync[1:0], shift_clk_i};
            cnv_sync <= {cnv_sync[1:0], conversion_trigger_i};
        end
    end
    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign cnv_rise = cnv_sync[1] & ~cnv_sync[2];

    // Saturation and two's complement coding of the held sample
    function automatic logic [RES_BITS-1:0] code_of(
        input logic [RES_BITS-1:0] raw, input logic ovr, input logic und);
        if (ovr)
            code_of = {1'b0, {(RES_BITS-1){1'b1}}};
        else if (und)
            code_of = {1'b1, {(RES_BITS-1){1'b0}}};
        else
            code_of = raw;
    endfunction

    // Conversion frame: trigger locked out until 16 shift edges
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            busy <= 1'b0;
            edge_cnt <= sapc_pkg::EDGE_CNT_ZERO;
        end else if (cnv_rise && !busy) begin
            busy <= 1'b1;
            edge_cnt <= sapc_pkg::EDGE_CNT_ZERO;
        end else if (busy && sck_rise) begin
            edge_cnt <= edge_cnt + 5'h01;
            if (edge_cnt + 5'h01 == LAST_EDGE)
                busy <= 1'b0;
        end
    end

    // Result from the previous conversion goes out this frame
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            shreg <= '0;
            held_code <= '0;
            serial_result_oe_o <= 1'b0;
        end else if (cnv_rise && !busy) begin
            shreg <= held_code;
            held_code <= code_of(sample_code_i, over_range_i, under_range_i);
            serial_result_oe_o <= 1'b0;
        end else if (busy && sck_rise) begin
            if (edge_cnt + 5'h01 >= FIRST_EDGE
                    && edge_cnt + 5'h01 < END_EDGE) begin
                serial_result_oe_o <= 1'b1;
                if (edge_cnt + 5'h01 > FIRST_EDGE)
                    shreg <= {shreg[RES_BITS-2:0], 1'b0};
            end else begin
                serial_result_oe_o <= 1'b0;
            end
        end else if (sck_rise) begin
            // Last bit must stand until the edge after the frame
            serial_result_oe_o <= 1'b0;
        end
    end
    assign serial_result_out_o = shreg[RES_BITS-1];

    // Trigger run counter and power state
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            trig_cnt <= sapc_pkg::TRIG_CNT_ZERO;
            power <= sapc_pkg::SAPC_ACTIVE;
        end else if (sck_rise) begin
            trig_cnt <= sapc_pkg::TRIG_CNT_ZERO;
            power <= sapc_pkg::SAPC_ACTIVE;
        end else if (cnv_rise) begin
            if (trig_cnt < SLEEP_N)
                trig_cnt <= trig_cnt + 3'h1;
            if (trig_cnt + 3'h1 >= SLEEP_N)
                power <= sapc_pkg::SAPC_SLEEP;
            else if (trig_cnt + 3'h1 >= NAP_N)
                power <= sapc_pkg::SAPC_NAP;
        end
    end
    assign nap_o = (power == sapc_pkg::SAPC_NAP);
    assign sleep_o = (power == sapc_pkg::SAPC_SLEEP);
    assign ref_powered_o = !sleep_o;

    // Reference settling after deep power-down
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)
            settle_cnt <= '0;
        else if (sleep_o)
            settle_cnt <= SETTLE_LOAD;
        else if (settle_cnt != '0)
            settle_cnt <= settle_cnt - SW'(1);
    end
    assign ref_settled_o = (settle_cnt == '0) && !sleep_o;

    AST_NAP_AFTER_TWO: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cnv_rise && !sck_rise && trig_cnt == 3'h1 |=> nap_o)
        else $error("light power-down not entered");
    AST_SLEEP_AFTER_FOUR: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        cnv_rise && !sck_rise && trig_cnt == 3'h3 |=> sleep_o)
        else $error("deep power-down not entered");
    AST_WAKE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        sck_rise |=> !nap_o && !sleep_o && trig_cnt == 3'h0)
        else $error("shift edge did not wake");
    AST_REF_NAP: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        nap_o |-> ref_powered_o)
        else $error("reference off in light power-down");
    AST_SETTLE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $fell(sleep_o) |-> !ref_settled_o)
        else $error("reference settled too early");
    AST_HIZ_IDLE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !busy && sck_rise |=> !serial_result_oe_o)
        else $error("output driven outside a frame");
    AST_LOCKOUT: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        busy && cnv_rise && !sck_rise |=> $stable(edge_cnt))
        else $error("retrigger not ignored");
    AST_FIRST_BIT: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        busy && sck_rise && edge_cnt == 5'h02 |=> serial_result_oe_o
        ##0 serial_result_out_o == $past(shreg[RES_BITS-1]))
        else $error("first bit not on third edge");
    AST_SAT_HIGH: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cnv_rise && !busy && over_range_i
        |=> held_code == {1'b0, {(RES_BITS-1){1'b1}}})
        else $error("over-range code wrong");
    AST_SAT_LOW: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cnv_rise && !busy && under_range_i && !over_range_i
        |=> held_code == {1'b1, {(RES_BITS-1){1'b0}}})
        else $error("under-range code wrong");

    // Steps of one frame, reused by the checks below
    sequence s_frame_start;
        cnv_rise && !busy;
    endsequence
    sequence s_lead_edge;
        busy && sck_rise && edge_cnt + 5'h01 < FIRST_EDGE;
    endsequence
    sequence s_data_edge;
        busy && sck_rise && edge_cnt + 5'h01 > FIRST_EDGE
            && edge_cnt + 5'h01 < END_EDGE;
    endsequence
    sequence s_last_edge;
        busy && sck_rise && edge_cnt + 5'h01 == LAST_EDGE;
    endsequence

    AST_BUSY_SET: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_frame_start |=> busy && edge_cnt == sapc_pkg::EDGE_CNT_ZERO)
        else $error("frame not started");
    AST_LOAD_PREV: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_frame_start |=> shreg == $past(held_code))
        else $error("previous result not loaded");
    AST_TAKE_SAMPLE: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_frame_start ##0 !over_range_i && !under_range_i
        |=> held_code == $past(sample_code_i))
        else $error("sample not held");
    AST_OE_OFF_START: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_frame_start |=> !serial_result_oe_o)
        else $error("output driven at frame start");
    AST_LEAD_QUIET: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_lead_edge |=> !serial_result_oe_o)
        else $error("output driven before third edge");
    AST_SHIFT_STEP: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_data_edge |=> serial_result_oe_o
            && shreg == {$past(shreg[RES_BITS-2:0]), 1'b0})
        else $error("result bit not advanced");
    AST_FRAME_END: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        s_last_edge |=> !busy)
        else $error("frame did not end on edge 16");
    AST_ONE_MODE: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        !(nap_o && sleep_o))
        else $error("both power-down modes at once");
    AST_SLEEP_REF_OFF: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        sleep_o |-> !ref_powered_o && !ref_settled_o)
        else $error("reference up in deep power-down");
    AST_SETTLE_LOAD: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        sleep_o |=> settle_cnt == SETTLE_LOAD)
        else $error("settle counter not loaded");
    // No disable here: this checks the reset itself
    AST_RESET_STATE: assert property (@(posedge sys_clk_i)
        srst_i |=> power == sapc_pkg::SAPC_ACTIVE
            && !serial_result_oe_o && !busy)
        else $error("not active after reset");
endmodule

// *** sapc_pkg.sv ***
// Notes on behaviour
// - Input above upper span gives zero-then-ones code
// - Input below lower span gives one-then-zeros code
// - Powers up active, ready to convert
// - Two triggers without shift edge: light power-down
// - Reference stays powered in light power-down
// - Shift edge wakes light power-down at once
// - Four triggers without shift edge: deep power-down
// - Shift edge wakes deep; reference settles 2ms
// - Three wires: shift clock, trigger, result out
// - Result resolves 16384 or 4096 code levels
// - Trigger starts conversion; retriggers ignored for 16 edges
// - Result MSB first from third shift edge
// - Result output high impedance when not sending
// - Two's complement of previous conversion's sample
package sapc_pkg;
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    localparam int unsigned REF_SETTLE_MS = 2;
    localparam int unsigned REF_SETTLE_CYC = SYS_CLK_HZ / 1000 * REF_SETTLE_MS;
    localparam int unsigned WIDE_BITS = 14;
    localparam int unsigned NARROW_BITS = 12;
    localparam int unsigned FRAME_EDGES = 16;
    localparam int unsigned FIRST_BIT_EDGE = 3;
    localparam int unsigned NAP_TRIGGERS = 2;
    localparam int unsigned SLEEP_TRIGGERS = 4;
    localparam logic [2:0] TRIG_CNT_ZERO = 3'h0;
    localparam logic [4:0] EDGE_CNT_ZERO = 5'h00;

    typedef enum logic [1:0] {
        SAPC_ACTIVE = 2'b00,
        SAPC_NAP = 2'b01,
        SAPC_SLEEP = 2'b11
    } sapc_power_e;
endpackage

// *** sapc_host_model.sv ***
module sapc_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Link pins, three wires only
    output logic shift_clk_o,
    output logic conversion_trigger_o,
    input wire logic serial_result_out_i,
    input wire logic serial_result_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clk_o = 1'b0;
        conversion_trigger_o = 1'b0;
    end
    // Half of a 160 ns link period
    task automatic half();
        repeat (10) @(posedge sys_clk_i);
    endtask
    // Caller spaces sleep entries far apart
    task automatic pulse_trig();
        conversion_trigger_o <= 1'b1;
        half();
        conversion_trigger_o <= 1'b0;
        half();
    endtask
    task automatic pulse_shift();
        shift_clk_o <= 1'b1;
        half();
        shift_clk_o <= 1'b0;
        half();
    endtask
    // Full 16 edges; with retrig set, a trigger pulse follows edge 8
    task automatic frame(input bit retrig, output logic [15:0] word,
                         output int nbits);
        word = 16'h0000;
        nbits = 0;
        pulse_trig();
        for (int i = 1; i <= 16; i++) begin
            shift_clk_o <= 1'b1;
            half();
            shift_clk_o <= 1'b0;
            conversion_trigger_o <= retrig && i == 8;
            // Bits ignored while the pin floats
            if (serial_result_oe_i === 1'b1) begin
                word = {word[14:0], serial_result_out_i};
                nbits++;
            end
            half();
        end
        conversion_trigger_o <= 1'b0;
    endtask
endmodule

// *** sapc_core_tb_top.sv ***
module sapc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, trig, dout, doe, nap, slp, rpw, rst_ok;
    logic ovr = 1'b0;
    logic und = 1'b0;
    logic [13:0] code = 14'h0000;
    int bad_count = 0;
    int compares = 0;
    always #4 clk = ~clk;
    sapc_core #(.RES_BITS(14), .SETTLE_CYC(50)) sapc_core_inst (
        .sys_clk_i(clk), .srst_i(srst), .shift_clk_i(sclk),
        .conversion_trigger_i(trig), .serial_result_out_o(dout),
        .serial_result_oe_o(doe), .sample_code_i(code), .over_range_i(ovr),
        .under_range_i(und), .nap_o(nap), .sleep_o(slp),
        .ref_powered_o(rpw), .ref_settled_o(rst_ok));
    sapc_host_model sapc_host_model_inst (.sys_clk_i(clk),
        .shift_clk_o(sclk), .conversion_trigger_o(trig),
        .serial_result_out_i(dout), .serial_result_oe_i(doe));
    task automatic check(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input bit rt, input logic [13:0] exp);
        logic [15:0] w;
        int n;
        sapc_host_model_inst.frame(rt, w, n);
        check("word", w, {2'b00, exp});
        check("bits", 16'(n), 16'h000E);
    endtask
    task automatic t_frames();
        check("oe", {15'h0000, doe}, 16'h0000);
        check("nap", {14'h0000, nap, slp}, 16'h0000);
        @(posedge clk) code <= 14'h1234;
        run(0, 14'h0000);
        @(posedge clk) code <= 14'h2ABC;
        run(1, 14'h1234);
        @(posedge clk) ovr <= 1'b1;
        run(0, 14'h2ABC);
        @(posedge clk) {ovr, und} <= 2'b01;
        run(0, 14'h1FFF);
        @(posedge clk) und <= 1'b0;
        run(0, 14'h2000);
    endtask
    task automatic t_power();
        sapc_host_model_inst.pulse_trig();
        sapc_host_model_inst.pulse_shift();
        sapc_host_model_inst.pulse_trig();
        check("nap", {15'h0000, nap}, 16'h0000);
        sapc_host_model_inst.pulse_trig();
        check("nap", {14'h0000, nap, rpw}, 16'h0003);
        sapc_host_model_inst.pulse_shift();
        check("nap", {15'h0000, nap}, 16'h0000);
        // The first power trigger opened a frame; finish it
        repeat (16) sapc_host_model_inst.pulse_shift();
        run(0, 14'h2ABC);
        repeat (4) sapc_host_model_inst.pulse_trig();
        check("slp", {14'h0000, slp, rpw}, 16'h0002);
        sapc_host_model_inst.pulse_shift();
        check("wake", {14'h0000, slp, rst_ok}, 16'h0000);
        repeat (60) @(posedge clk);
        check("settle", {15'h0000, rst_ok}, 16'h0001);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_frames();
        t_power();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
